/* rtl/pfr_read_port.sv */
`timescale 1ns/100ps
module pfr_read_port
    import pfr_pkg::*;
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [pfr_pkg::BUS_AW-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [pfr_pkg::BUS_AW-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic                             flash_rd,
    output logic [pfr_pkg::ADDR_W-1:0]       flash_addr,
    input  wire logic [pfr_pkg::WORD_W-1:0]  flash_rdata,
    output logic                             insn_discard,
    output logic                             read_busy
);
    logic                aw_hold_q, aw_hold_d;
    logic [BUS_AW-1:0]   aw_addr_q, aw_addr_d;
    logic                w_hold_q, w_hold_d;
    logic [7:0]          w_byte_q, w_byte_d;
    logic                w_lane_q, w_lane_d;
    logic                bvalid_q, bvalid_d;
    logic [1:0]          bresp_q, bresp_d;
    logic                rvalid_q, rvalid_d;
    logic [1:0]          rresp_q, rresp_d;
    logic [31:0]         rdata_q, rdata_d;
    logic                start_q, start_d;
    logic [4:0]          adr_hi_q, adr_hi_d;
    logic [7:0]          adr_lo_q, adr_lo_d;
    logic [5:0]          dat_hi_q, dat_hi_d;
    logic [7:0]          dat_lo_q, dat_lo_d;
    logic                disc_q, disc_d;
    logic                busy_q, busy_d;
    logic                go_q, go_d;
    logic                awready_q, awready_d;
    logic                wready_q, wready_d;
    logic                arready_q, arready_d;
    logic                do_write;
    logic                seq_rd, seq_disc, seq_done;
    logic [ADDR_W-1:0]   seq_addr;
    logic [WORD_W-1:0]   seq_word;

    // mapped-offset check shared by read and write decode
    function automatic logic is_mapped(input logic [BUS_AW-1:0] a);
        is_mapped = (a == OFF_CONTROL) || (a == OFF_DATA_HIGH) || (a == OFF_DATA_LOW) ||
                    (a == OFF_ADDR_HIGH) || (a == OFF_ADDR_LOW) || (a == OFF_DISCARD);
    endfunction

    // zero-extend one register byte onto the 32-bit read bus
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h0, b};
    endfunction

    // fetch sequencer
    pfr_flash_seq u_seq
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (go_q),
        .addr        ({adr_hi_q, adr_lo_q}),
        .flash_rdata (flash_rdata),
        .flash_rd    (seq_rd),
        .flash_addr  (seq_addr),
        .discard     (seq_disc),
        .done        (seq_done),
        .word        (seq_word)
    );

    // a write commits once address and data are both held and no response is pending
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

    // write channel capture in either order, then one response
    always_comb
    begin
        aw_hold_d = aw_hold_q;
        aw_addr_d = aw_addr_q;
        w_hold_d  = w_hold_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        // capture each channel on its own handshake
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        // readiness is registered so every handshake output comes from a flop
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
    end

    // register file; completion clear loses to a fresh software set
    always_comb
    begin
        start_d  = start_q;
        go_d     = 1'b0;
        adr_hi_d = adr_hi_q;
        adr_lo_d = adr_lo_q;
        dat_hi_d = dat_hi_q;
        dat_lo_d = dat_lo_q;
        disc_d   = seq_disc ? 1'b1 : disc_q;
        busy_d   = start_q;
        // a completed fetch loads the data pair and drops the start bit
        if (seq_done)
        begin
            start_d  = 1'b0;
            dat_hi_d = seq_word[WORD_W-1:8];
            dat_lo_d = seq_word[7:0];
        end
        // software writes land through byte lane 0 only
        if (do_write && w_lane_q)
        begin
            case (aw_addr_q)
                OFF_CONTROL:
                begin
                    if (w_byte_q[START_BIT] && (!start_q || seq_done))
                    begin
                        start_d = 1'b1;
                        go_d    = 1'b1;
                    end
                end
                OFF_DATA_HIGH:
                begin
                    dat_hi_d = w_byte_q[5:0];
                end
                OFF_DATA_LOW:
                begin
                    dat_lo_d = w_byte_q;
                end
                OFF_ADDR_HIGH:
                begin
                    adr_hi_d = w_byte_q[4:0];
                end
                OFF_ADDR_LOW:
                begin
                    adr_lo_d = w_byte_q;
                end
                OFF_DISCARD:
                begin
                    disc_d = disc_q & ~w_byte_q[0];
                end
                default:
                begin
                    go_d = 1'b0;                            // unmapped offset writes nothing
                end
            endcase
        end
        // the discard flag's hardware set wins over a same-cycle clear
        if (seq_disc)
        begin
            disc_d = 1'b1;
        end
    end

    // read channel with zero-filled unimplemented bits, except control bit 7 (RSVD_BIT), which reads as one
    always_comb
    begin
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        // answer a taken read address in the next cycle
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFF_CONTROL:
                begin
                    rdata_d = byte_word(CONTROL_RESET | {7'h0, start_q});
                end
                OFF_DATA_HIGH:
                begin
                    rdata_d = byte_word({2'h0, dat_hi_q});
                end
                OFF_DATA_LOW:
                begin
                    rdata_d = byte_word(dat_lo_q);
                end
                OFF_ADDR_HIGH:
                begin
                    rdata_d = byte_word({3'h0, adr_hi_q});
                end
                OFF_ADDR_LOW:
                begin
                    rdata_d = byte_word(adr_lo_q);
                end
                OFF_DISCARD:
                begin
                    rdata_d = byte_word({7'h0, disc_q});
                end
                default:
                begin
                    rdata_d = 32'h0;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        // a new read address is taken only while no answer is pending
        arready_d = !rvalid_d;
    end

    // all registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_hold_q  <= 1'b0;
            w_byte_q  <= BYTE_RESET;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0;
            start_q   <= 1'b0;
            go_q      <= 1'b0;
            adr_hi_q  <= 5'h00;
            adr_lo_q  <= BYTE_RESET;
            dat_hi_q  <= 6'h00;
            dat_lo_q  <= BYTE_RESET;
            disc_q    <= 1'b0;
            busy_q    <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            arready_q <= 1'b1;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            aw_addr_q <= aw_addr_d;
            w_hold_q  <= w_hold_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            start_q   <= start_d;
            go_q      <= go_d;
            adr_hi_q  <= adr_hi_d;
            adr_lo_q  <= adr_lo_d;
            dat_hi_q  <= dat_hi_d;
            dat_lo_q  <= dat_lo_d;
            disc_q    <= disc_d;
            busy_q    <= busy_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    // bus handshake outputs, all flop-driven
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // sequencer outputs pass through; they are flops inside the sequencer
    assign flash_rd      = seq_rd;
    assign flash_addr    = seq_addr;
    assign insn_discard  = seq_disc;
    assign read_busy     = busy_q;
endmodule

/* rtl/pfr_pkg.sv */
package pfr_pkg;
    localparam int          ADDR_W         = 13;
    localparam int          WORD_W         = 14;
    localparam int          BUS_AW         = 5;
    localparam logic [4:0]  OFF_CONTROL    = 5'h00;
    localparam logic [4:0]  OFF_DATA_HIGH  = 5'h04;
    localparam logic [4:0]  OFF_DATA_LOW   = 5'h08;
    localparam logic [4:0]  OFF_ADDR_HIGH  = 5'h0c;
    localparam logic [4:0]  OFF_ADDR_LOW   = 5'h10;
    localparam logic [4:0]  OFF_DISCARD    = 5'h14;
    localparam int          START_BIT      = 0;
    localparam int          RSVD_BIT       = 7;
    localparam logic [7:0]  CONTROL_RESET  = 8'h80;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [1:0]  FETCH_CYCLES   = 2'h2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_LOAD  = 3'b100
    } pfr_state_t;
endpackage

/* rtl/pfr_flash_seq.sv */
`timescale 1ns/100ps
module pfr_flash_seq
    import pfr_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    start,
    input  wire logic [pfr_pkg::ADDR_W-1:0] addr,
    input  wire logic [pfr_pkg::WORD_W-1:0] flash_rdata,
    output logic                         flash_rd,
    output logic [pfr_pkg::ADDR_W-1:0]   flash_addr,
    output logic                         discard,
    output logic                         done,
    output logic [pfr_pkg::WORD_W-1:0]   word
);
    pfr_state_t              state_q, state_d;
    logic [1:0]              cnt_q, cnt_d;
    logic                    rd_q, rd_d;
    logic                    disc_q, disc_d;
    logic                    done_q, done_d;
    logic [ADDR_W-1:0]       fa_q, fa_d;
    logic [WORD_W-1:0]       word_q, word_d;

    // two-cycle fetch sequencer; no protection input exists here
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rd_d    = 1'b0;
        disc_d  = 1'b0;
        done_d  = 1'b0;
        fa_d    = fa_q;
        word_d  = word_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    state_d = ST_FETCH;
                    cnt_d   = 2'h1;
                    rd_d    = 1'b1;
                    fa_d    = addr;
                end
            end
            ST_FETCH:
            begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == FETCH_CYCLES - 2'h1)
                begin
                    disc_d  = 1'b1;
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                word_d  = flash_rdata;
                done_d  = 1'b1;
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
            rd_q    <= 1'b0;
            disc_q  <= 1'b0;
            done_q  <= 1'b0;
            fa_q    <= '0;
            word_q  <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rd_q    <= rd_d;
            disc_q  <= disc_d;
            done_q  <= done_d;
            fa_q    <= fa_d;
            word_q  <= word_d;
        end
    end

    assign flash_rd   = rd_q;
    assign flash_addr = fa_q;
    assign discard    = disc_q;
    assign done       = done_q;
    assign word       = word_q;
endmodule

/* testbench/pfr_read_port_props.sv */
`timescale 1ns/100ps
module pfr_read_port_props
    import pfr_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        flash_rd,
    input wire logic        insn_discard,
    input wire logic        read_busy
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a fetch request is followed by the discarded slot
    sequence s_fetch;
        flash_rd ##1 insn_discard;
    endsequence
    // busy covers the whole fetch, then drops
    sequence s_busy_run;
        read_busy [*4] ##1 !read_busy;
    endsequence
    property p_rd_discard;
        flash_rd |-> s_fetch;
    endproperty
    a_rd_discard: assert property (p_rd_discard)
        else $error("no discard slot after fetch");
    property p_busy_len;
        flash_rd |-> s_busy_run;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy span wrong");
    property p_busy_start;
        $rose(read_busy) |-> flash_rd;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy without fetch");
    property p_discard_src;
        insn_discard |-> $past(flash_rd);
    endproperty
    a_discard_src: assert property (p_discard_src)
        else $error("stray discard");
    property p_rd_single;
        flash_rd |=> !flash_rd [*4];
    endproperty
    a_rd_single: assert property (p_rd_single)
        else $error("second fetch too soon");
    property p_busy_end;
        $fell(read_busy) |-> $past(insn_discard, 3);
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy ended off time");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_r_upper: assert property (p_r_upper)
        else $error("upper read bits set");
endmodule

/* testbench/pfr_flash_model.sv */
`timescale 1ns/100ps
module pfr_flash_model
    import pfr_pkg::*;
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       flash_rd,
    input  wire logic [pfr_pkg::ADDR_W-1:0] flash_addr,
    output logic      [pfr_pkg::WORD_W-1:0] flash_rdata,
    output logic      [pfr_pkg::ADDR_W-1:0] last_addr,
    output logic      [31:0]                rd_count
);
    logic [1:0]        hold_q;
    logic [WORD_W-1:0] word;
    // latch the fetch address, keep the word valid through the load slot
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_q <= 2'h0;
            rd_count <= 32'h0;
            last_addr <= '0;
        end
        else if (flash_rd)
        begin
            last_addr <= flash_addr;
            rd_count <= rd_count + 32'h1;
            hold_q <= 2'h3;
        end
        else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
    end
    // outside the valid window the array shows the inverted word
    assign word = {~last_addr[12:7], last_addr[7:0] ^ 8'h5c};
    assign flash_rdata = (hold_q != 2'h0) ? word : ~word;
endmodule

/* testbench/program_flash_read_port_tb.sv */
`timescale 1ns/100ps
module program_flash_read_port_tb;
    import pfr_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic flash_rd, insn_discard, read_busy;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_count, fail_count, num_checks;
    logic [3:0]  s_axi_wstrb, strb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [12:0] flash_addr, last_addr;
    logic [13:0] flash_rdata;
    pfr_read_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .insn_discard(insn_discard), .read_busy(read_busy));
    pfr_flash_model fm_u (.aclk(aclk), .aresetn(aresetn), .flash_rd(flash_rd),
        .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .last_addr(last_addr), .rd_count(rd_count));
    // clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 32'h1;
        if (got !== exp)
        begin
            fail_count = fail_count + 32'h1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1)
            begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // read: rready raised with the request and held until rvalid is sampled
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd(OFF_CONTROL, d, r);
        chk(d, 32'h80);
        rd(5'h18, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        wr(5'h18, 32'hff, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFF_ADDR_HIGH, 32'hff, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rd(OFF_ADDR_HIGH, d, r);
        chk(d, 32'h1f);
        wr(OFF_DATA_HIGH, 32'hff, r);
        rd(OFF_DATA_HIGH, d, r);
        chk(d, 32'h3f);
        wr(OFF_CONTROL, 32'h80, r);
        rd(OFF_CONTROL, d, r);
        chk(d, 32'h80);
        wr(OFF_ADDR_LOW, 32'h3c, r);
        strb = 4'h0;
        wr(OFF_ADDR_LOW, 32'hc3, r);
        strb = 4'hf;
        rd(OFF_ADDR_LOW, d, r);
        chk(d, 32'h3c);
        $display("register test done");
    endtask
    task automatic t_fetch(input logic [12:0] a);
        logic [31:0] d, n;
        logic [1:0]  r;
        n = rd_count;
        wr(OFF_ADDR_HIGH, {27'h0, a[12:8]}, r);
        wr(OFF_ADDR_LOW, {24'h0, a[7:0]}, r);
        wr(OFF_CONTROL, 32'h81, r);
        d = 32'h1;
        while (d[0] !== 1'b0) rd(OFF_CONTROL, d, r);
        chk(d, 32'h80);
        chk({19'h0, last_addr}, {19'h0, a});
        rd(OFF_DATA_HIGH, d, r);
        chk(d, {26'h0, ~a[12:7]});
        rd(OFF_DATA_LOW, d, r);
        chk(d, {24'h0, a[7:0] ^ 8'h5c});
        rd(OFF_DISCARD, d, r);
        chk(d, 32'h1);
        wr(OFF_DISCARD, 32'h1, r);
        rd(OFF_DISCARD, d, r);
        chk(d, 32'h0);
        wr(OFF_CONTROL, 32'h80, r);
        rd(OFF_DATA_LOW, d, r);
        chk(d, {24'h0, a[7:0] ^ 8'h5c});
        chk(rd_count, n + 32'h1);
        $display("fetch test done");
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CONTROL, d, r);
        chk(d, 32'h80);
        rd(OFF_DATA_LOW, d, r);
        chk(d, 32'h0);
        $display("reset test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 32'h0 && num_checks != 32'h0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count = fail_count + 32'h1;
        finish_test();
    end
    // main sequence
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, strb} = 8'hff;
        {fail_count, num_checks} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fetch(13'h1fff);
        t_fetch(13'h00a5);
        t_reset();
        finish_test();
    end
endmodule
bind pfr_read_port pfr_read_port_props pr_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .flash_rd(flash_rd), .insn_discard(insn_discard), .read_busy(read_busy));
